/* bench/ahc_checker.sv */
`timescale 1ns/1ps
module ahc_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic engine_to_host_irq,
  input wire logic engine_wake_tick,
  input wire logic clock_request,
  input wire logic smart_idle_allow
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] gap_r;
  logic seen_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_r <= 8'h00;
      seen_r <= 1'b0;
    end else if (engine_wake_tick) begin
      gap_r <= 8'h00;
      seen_r <= 1'b1;
    end else if (gap_r != 8'hff) begin
      gap_r <= gap_r + 8'h01;
    end
  end
  sequence s_aw_taken; s_axi_awready; endsequence
  sequence s_b_shown; ##[1:3] s_axi_bvalid; endsequence
  a_write_answer: assert property (s_aw_taken |-> s_b_shown) else $error("no write response");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  a_read_answer: assert property (s_axi_arready |=> s_axi_rvalid) else $error("no read data");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  a_tick_pulse: assert property (engine_wake_tick |=> !engine_wake_tick)
    else $error("tick longer than one cycle");
  a_tick_spacing: assert property (engine_wake_tick |->
    !seen_r || gap_r == 8'h63 || gap_r == 8'hff) else $error("tick spacing wrong");
  a_idle_clock_req: assert property (!smart_idle_allow &&
    !$past(smart_idle_allow) |-> clock_request)
    else $error("clock request dropped without autogate");
  a_irq_fall_cause: assert property ($fell(engine_to_host_irq) |->
    s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("interrupt fell without a write");
endmodule : ahc_checker
bind ahc_host_ctrl ahc_checker ahc_checker_i (.clk(clk), .rst(rst), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .engine_to_host_irq(engine_to_host_irq), .engine_wake_tick(engine_wake_tick),
  .clock_request(clock_request), .smart_idle_allow(smart_idle_allow));

/* bench/ahc_host_model.sv */
`timescale 1ns/1ps
module ahc_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic irq,
  input wire logic [7:0] dma_req,
  output logic [7:0] irq_rises,
  output logic [7:0] dma_seen
);
  logic irq_q;
  // Counts service calls and records request lines seen
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
      irq_rises <= 8'h00;
      dma_seen <= 8'h00;
    end else begin
      irq_q <= irq;
      if (irq && !irq_q) irq_rises <= irq_rises + 8'h01;
      dma_seen <= dma_seen | dma_req;
    end
  end
endmodule : ahc_host_model

/* bench/tb_audio_subsystem_host_control.sv */
`timescale 1ns/1ps
module tb_audio_subsystem_host_control;
  logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, irq, tick, creq, idle;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, engine_data, d;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] dir_rx, push, pop, dma, irq_rises, dma_seen;
  int mismatches, checks_done, cyc, t0;
  ahc_host_ctrl ahc_host_ctrl_i (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ring_dir_rx(dir_rx),
    .engine_push(push), .engine_pop(pop), .engine_data(engine_data),
    .system_dma_request_in(dma), .engine_to_host_irq(irq), .engine_wake_tick(tick),
    .clock_request(creq), .smart_idle_allow(idle));
  ahc_host_model ahc_host_model_i (.clk(clk), .rst(rst), .irq(irq), .dma_req(dma),
    .irq_rises(irq_rises), .dma_seen(dma_seen));
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    resp = bresp;
    bready <= 0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 0;
  endtask : rd
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask : settle
  task automatic t_regs();
    rd(ahc_pkg::OFF_TICK_RELOAD);
    chk("reload reset", 32'h0000_0800, d);
    rd(12'h200);
    chk("unmapped read resp", {30'h0, ahc_pkg::RESP_SLVERR}, {30'h0, resp});
    wr(12'h200, 32'h0000_0001);
    chk("unmapped write resp", {30'h0, ahc_pkg::RESP_SLVERR}, {30'h0, resp});
    wr(ahc_pkg::OFF_TICK_RELOAD, 32'h0000_0800);
    chk("write resp", {30'h0, ahc_pkg::RESP_OKAY}, {30'h0, resp});
    rd(ahc_pkg::OFF_TICK_RELOAD);
    chk("reload readback", 32'h0000_0800, d);
    $display("test regs done");
  endtask : t_regs
  task automatic t_tick_irq();
    wr(ahc_pkg::OFF_IRQ_EN_SET, 32'h0000_0100);
    wr(ahc_pkg::OFF_IRQ_EN_SET, 32'h0000_0000);
    rd(ahc_pkg::OFF_IRQ_EN_SET);
    chk("mask via set", 32'h0000_0100, d);
    rd(ahc_pkg::OFF_IRQ_EN_CLR);
    chk("mask via clr", 32'h0000_0100, d);
    wr(ahc_pkg::OFF_TICK_SRC, 32'h1);
    wr(ahc_pkg::OFF_TICK_RUN, 32'h1);
    @(posedge clk iff tick);
    t0 = cyc;
    @(posedge clk iff tick);
    chk("tick gap", 32'(ahc_pkg::TICK_CYCLES), 32'(cyc - t0));
    rd(ahc_pkg::OFF_TICK_COUNT);
    chk("tick count", 32'h2, d);
    wr(ahc_pkg::OFF_TICK_RUN, 32'h0);
    settle();
    chk("irq on", 32'h1, {31'h0, irq});
    rd(ahc_pkg::OFF_IRQ_STATUS);
    chk("tick status", 32'h1, {31'h0, d[8]});
    wr(ahc_pkg::OFF_IRQ_EN_CLR, 32'h0000_0100);
    settle();
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(ahc_pkg::OFF_IRQ_EN_SET);
    chk("mask cleared", 32'h0, d);
    wr(ahc_pkg::OFF_IRQ_EN_SET, 32'h0000_0100);
    settle();
    chk("irq again", 32'h1, {31'h0, irq});
    wr(ahc_pkg::OFF_IRQ_STATUS, 32'h0000_0100);
    settle();
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd(ahc_pkg::OFF_IRQ_STATUS);
    chk("status cleared", 32'h0, {31'h0, d[8]});
    chk("host irq count", 32'h2, {24'h0, irq_rises});
    $display("test tick and interrupt done");
  endtask : t_tick_irq
  task automatic t_ring();
    wr(ahc_pkg::OFF_DMA_EN_SET, 32'h3);
    rd(ahc_pkg::OFF_DMA_EN_SET);
    chk("dma enables", 32'h3, d);
    settle();
    chk("dma idle", 32'h01, {24'h0, dma});
    for (int i = 0; i < 5; i++) begin
      wr(ahc_pkg::OFF_RING_BASE, 32'(i));
    end
    settle();
    chk("dma full", 32'h0, {31'h0, dma[0]});
    pop <= 8'h01;
    repeat (3) @(posedge clk);
    pop <= 8'h00;
    settle();
    chk("dma below half", 32'h1, {31'h0, dma[0]});
    pop <= 8'h01;
    repeat (2) @(posedge clk);
    pop <= 8'h00;
    for (int i = 0; i < 3; i++) begin
      push <= 8'h02;
      engine_data <= 32'hc0de_0000 + 32'(i);
      @(posedge clk);
    end
    push <= 8'h00;
    settle();
    chk("capture dma", 32'h1, {31'h0, dma[1]});
    rd(ahc_pkg::OFF_IRQ_STATUS);
    chk("ring events", 32'h03, {24'h0, d[7:0]});
    for (int i = 0; i < 3; i++) begin
      rd(12'h104);
      chk("capture word", 32'hc0de_0000 + 32'(i), d);
    end
    chk("host dma seen", 32'h03, {24'h0, dma_seen});
    wr(ahc_pkg::OFF_DMA_EN_CLR, 32'h1);
    rd(ahc_pkg::OFF_DMA_EN_SET);
    chk("dma enable clear", 32'h2, d);
    $display("test ring done");
  endtask : t_ring
  task automatic t_gate();
    wr(ahc_pkg::OFF_AUTOGATE, 32'h1);
    settle();
    chk("idle allow", 32'h1, {31'h0, idle});
    chk("clock released", 32'h0, {31'h0, creq});
    wr(ahc_pkg::OFF_AUTOGATE, 32'h0);
    settle();
    chk("clock requested", 32'h1, {31'h0, creq});
    $display("test autogate done");
  endtask : t_gate
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  initial begin
    rst = 1; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 12'h000; araddr = 12'h000; wdata = 32'h0; engine_data = 32'h0;
    dir_rx = 8'h02; push = 8'h00; pop = 8'h00; cyc = 0;
    repeat (4) @(posedge clk);
    rst <= 0;
    t_regs();
    t_tick_irq();
    t_ring();
    t_gate();
    end_of_test();
  end
endmodule : tb_audio_subsystem_host_control

/* hw/ahc_host_ctrl.sv */
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ahc_host_ctrl #(
  parameter int LINES = ahc_pkg::NUM_LINES,
  parameter int DEPTH = ahc_pkg::RING_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [LINES-1:0] ring_dir_rx,
  input wire logic [LINES-1:0] engine_push,
  input wire logic [LINES-1:0] engine_pop,
  input wire logic [31:0] engine_data,
  output logic [LINES-1:0] system_dma_request_in,
  output logic engine_to_host_irq,
  output logic engine_wake_tick,
  output logic clock_request,
  output logic smart_idle_allow
);
  // ****************************************************
  // Register state
  // ****************************************************
  logic [31:0] irq_status_r;
  logic [31:0] irq_mask_r;
  logic [LINES-1:0] dma_en_r;
  logic [31:0] tick_reload_r;
  logic tick_run_r;
  logic tick_src_r;
  logic autogate_r;
  logic [LINES-1:0] half_q_r;
  logic [LINES-1:0] dir_s1_r;
  logic [LINES-1:0] dir_r;
  logic tick;
  logic [31:0] tick_count;

  // ****************************************************
  // Write channel
  // ****************************************************
  logic [11:0] aw_addr_r;
  logic aw_have_r;
  logic [31:0] w_data_r;
  logic w_have_r;
  logic wr_fire;
  logic [11:0] wa;
  logic [31:0] wd;
  logic wr_hit;
  logic [LINES-1:0] ring_wsel;

  function automatic logic is_ring(input logic [11:0] a);
    return a >= ahc_pkg::OFF_RING_BASE && a <= ahc_pkg::OFF_RING_LAST && a[1:0] == 2'b00;
  endfunction : is_ring

  function automatic logic is_mapped(input logic [11:0] a);
    return is_ring(a) || a == ahc_pkg::OFF_IRQ_STATUS || a == ahc_pkg::OFF_IRQ_EN_SET ||
      a == ahc_pkg::OFF_IRQ_EN_CLR || a == ahc_pkg::OFF_DMA_EN_SET ||
      a == ahc_pkg::OFF_DMA_EN_CLR || a == ahc_pkg::OFF_TICK_RELOAD ||
      a == ahc_pkg::OFF_TICK_RUN || a == ahc_pkg::OFF_TICK_SRC ||
      a == ahc_pkg::OFF_TICK_COUNT || a == ahc_pkg::OFF_AUTOGATE;
  endfunction : is_mapped

  assign wa = aw_addr_r;
  assign wd = w_data_r;
  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_hit = wr_fire && is_mapped(wa);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_have_r <= 1'b0;
      w_data_r <= '0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
      end else if (wr_fire) begin
        w_have_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ahc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(wa) ? ahc_pkg::RESP_OKAY : ahc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************
  // Read channel
  // ****************************************************
  logic rd_fire;
  logic [11:0] ra;
  logic [LINES-1:0] ring_rsel;
  logic [31:0] rd_mux;
  logic [31:0] ring_rdata [LINES];

  assign ra = s_axi_araddr;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // ****************************************************
  // Ring buffers, one per request line
  // ****************************************************
  logic [LINES-1:0] ring_empty;
  logic [LINES-1:0] ring_half;
  logic [LINES-1:0] ring_half_rise;

  genvar gi;
  generate
    for (gi = 0; gi < LINES; gi++) begin : g_ring
      ahc_ring_if rif ();
      logic host_w;
      logic host_r;
      assign ring_wsel[gi] = wr_hit && is_ring(wa) && wa[4:2] == 3'(gi);
      assign ring_rsel[gi] = rd_fire && is_ring(ra) && ra[4:2] == 3'(gi);
      assign host_w = ring_wsel[gi] && !dir_r[gi];
      assign host_r = ring_rsel[gi] && dir_r[gi];
      // Host fills playback rings, engine fills capture rings
      assign rif.wr_en = dir_r[gi] ? engine_push[gi] : host_w;
      assign rif.rd_en = dir_r[gi] ? host_r : engine_pop[gi];
      assign rif.wr_data = dir_r[gi] ? engine_data : wd;
      assign ring_rdata[gi] = rif.rd_data;
      assign ring_empty[gi] = rif.empty;
      assign ring_half[gi] = dir_r[gi] ? rif.half : !rif.half;
      ahc_ring_fifo #(.DEPTH(DEPTH)) u_ring (
        .clk(clk),
        .rst(rst),
        .rp(rif)
      );
    end
  endgenerate

  assign ring_half_rise = ring_half & ~half_q_r;

  always_comb begin
    rd_mux = 32'h0;
    if (is_ring(ra)) begin
      rd_mux = ring_rdata[ra[4:2]];
    end else begin
      unique case (ra)
        ahc_pkg::OFF_IRQ_STATUS: rd_mux = irq_status_r;
        ahc_pkg::OFF_IRQ_EN_SET: rd_mux = irq_mask_r;
        ahc_pkg::OFF_IRQ_EN_CLR: rd_mux = irq_mask_r;
        ahc_pkg::OFF_DMA_EN_SET: rd_mux = 32'(dma_en_r);
        ahc_pkg::OFF_DMA_EN_CLR: rd_mux = 32'(dma_en_r);
        ahc_pkg::OFF_TICK_RELOAD: rd_mux = tick_reload_r;
        ahc_pkg::OFF_TICK_RUN: rd_mux = {31'h0, tick_run_r};
        ahc_pkg::OFF_TICK_SRC: rd_mux = {31'h0, tick_src_r};
        ahc_pkg::OFF_TICK_COUNT: rd_mux = tick_count;
        ahc_pkg::OFF_AUTOGATE: rd_mux = {31'h0, autogate_r};
        default: rd_mux = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= ahc_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= is_mapped(ra) ? ahc_pkg::RESP_OKAY : ahc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************
  // Tick generator
  // ****************************************************
  logic tick_go;

  assign tick_go = tick_run_r && tick_src_r;

  ahc_tick_gen u_tick (
    .clk(clk),
    .rst(rst),
    .run(tick_go),
    .reload(tick_reload_r),
    .tick(tick),
    .count(tick_count)
  );

  // ****************************************************
  // Control registers
  // ****************************************************
  logic [31:0] irq_events;
  logic [31:0] irq_clr;
  logic we_status;
  logic we_mask_set;
  logic we_mask_clr;
  logic we_dma_set;
  logic we_dma_clr;
  logic we_reload;
  logic we_run;
  logic we_src;
  logic we_autogate;

  assign we_status = wr_hit && wa == ahc_pkg::OFF_IRQ_STATUS;
  assign we_mask_set = wr_hit && wa == ahc_pkg::OFF_IRQ_EN_SET;
  assign we_mask_clr = wr_hit && wa == ahc_pkg::OFF_IRQ_EN_CLR;
  assign we_dma_set = wr_hit && wa == ahc_pkg::OFF_DMA_EN_SET;
  assign we_dma_clr = wr_hit && wa == ahc_pkg::OFF_DMA_EN_CLR;
  assign we_reload = wr_hit && wa == ahc_pkg::OFF_TICK_RELOAD;
  assign we_run = wr_hit && wa == ahc_pkg::OFF_TICK_RUN;
  assign we_src = wr_hit && wa == ahc_pkg::OFF_TICK_SRC;
  assign we_autogate = wr_hit && wa == ahc_pkg::OFF_AUTOGATE;
  assign irq_events = {23'h0, tick, 8'(ring_half_rise)};
  assign irq_clr = we_status ? wd : 32'h0;

  // Edge history starts at the empty playback level: no false event after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_status_r <= '0;
      half_q_r <= '1;
    end else begin
      half_q_r <= ring_half;
      irq_status_r <= (irq_status_r & ~irq_clr) | irq_events;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_mask_r <= '0;
      dma_en_r <= '0;
    end else begin
      if (we_mask_set) begin
        irq_mask_r <= irq_mask_r | wd;
      end else if (we_mask_clr) begin
        irq_mask_r <= irq_mask_r & ~wd;
      end
      if (we_dma_set) begin
        dma_en_r <= dma_en_r | wd[LINES-1:0];
      end else if (we_dma_clr) begin
        dma_en_r <= dma_en_r & ~wd[LINES-1:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_reload_r <= ahc_pkg::RST_TICK_RELOAD;
      tick_run_r <= 1'b0;
      tick_src_r <= 1'b0;
      autogate_r <= 1'b0;
    end else begin
      if (we_reload) begin
        tick_reload_r <= wd;
      end
      if (we_run) begin
        tick_run_r <= wd[0];
      end
      if (we_src) begin
        tick_src_r <= wd[0];
      end
      if (we_autogate) begin
        autogate_r <= wd[0];
      end
    end
  end

  // ****************************************************
  // Direction strap synchroniser and outputs
  // ****************************************************
  logic any_busy;
  assign any_busy = tick_go || |(~ring_empty & dma_en_r);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dir_s1_r <= '0;
      dir_r <= '0;
      system_dma_request_in <= '0;
      engine_to_host_irq <= 1'b0;
      engine_wake_tick <= 1'b0;
      clock_request <= 1'b1;
      smart_idle_allow <= 1'b0;
    end else begin
      dir_s1_r <= ring_dir_rx;
      dir_r <= dir_s1_r;
      system_dma_request_in <= dma_en_r & ring_half;
      engine_to_host_irq <= |(irq_status_r & irq_mask_r);
      engine_wake_tick <= tick;
      smart_idle_allow <= autogate_r;
      clock_request <= !(autogate_r && !any_busy);
    end
  end
endmodule : ahc_host_ctrl

/* hw/ahc_pkg.sv */
package ahc_pkg;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h028;
  localparam logic [11:0] OFF_IRQ_EN_SET = 12'h03c;
  localparam logic [11:0] OFF_IRQ_EN_CLR = 12'h040;
  localparam logic [11:0] OFF_DMA_EN_SET = 12'h060;
  localparam logic [11:0] OFF_DMA_EN_CLR = 12'h064;
  localparam logic [11:0] OFF_TICK_RELOAD = 12'h068;
  localparam logic [11:0] OFF_TICK_RUN = 12'h06c;
  localparam logic [11:0] OFF_TICK_SRC = 12'h070;
  localparam logic [11:0] OFF_TICK_COUNT = 12'h074;
  localparam logic [11:0] OFF_AUTOGATE = 12'h07c;
  localparam logic [11:0] OFF_RING_BASE = 12'h100;
  localparam logic [11:0] OFF_RING_LAST = 12'h11c;
  localparam logic [31:0] RST_TICK_RELOAD = 32'h0000_0800;
  localparam int TICK_PERIOD_NS = 10000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int NUM_LINES = 8;
  localparam int RING_DEPTH = 4;
  localparam int IRQ_TICK_BIT = 8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : ahc_pkg

/* hw/ahc_ring_fifo.sv */
`timescale 1ns/1ps
module ahc_ring_fifo #(
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  ahc_ring_if.owner rp
);
  localparam int AW = $clog2(DEPTH);
  logic [31:0] mem [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rdp_r;
  logic [AW:0] level;
  logic do_wr;
  logic do_rd;
  assign level = wp_r - rdp_r;
  assign rp.full = level == (AW + 1)'(DEPTH);
  assign rp.empty = level == '0;
  assign rp.half = level >= (AW + 1)'(DEPTH / 2);
  assign rp.rd_data = mem[rdp_r[AW-1:0]];
  assign do_wr = rp.wr_en && !rp.full;
  assign do_rd = rp.rd_en && !rp.empty;
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wp_r[AW-1:0]] <= rp.wr_data;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
      rdp_r <= '0;
    end else begin
      if (do_wr) begin
        wp_r <= wp_r + 1'b1;
      end
      if (do_rd) begin
        rdp_r <= rdp_r + 1'b1;
      end
    end
  end
endmodule : ahc_ring_fifo

/* hw/ahc_ring_if.sv */
`timescale 1ns/1ps
interface ahc_ring_if;
  logic wr_en;
  logic rd_en;
  logic [31:0] wr_data;
  logic [31:0] rd_data;
  logic full;
  logic empty;
  logic half;
  modport owner (input wr_en, input rd_en, input wr_data, output rd_data, output full,
    output empty, output half);
  modport user (output wr_en, output rd_en, output wr_data, input rd_data, input full,
    input empty, input half);
endinterface : ahc_ring_if

/* hw/ahc_tick_gen.sv */
`timescale 1ns/1ps
module ahc_tick_gen (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [31:0] reload,
  output logic tick,
  output logic [31:0] count
);
  logic [31:0] cnt_r;
  logic [15:0] div_r;
  logic base_en;
  localparam logic [15:0] DIV_LAST = 16'(ahc_pkg::TICK_CYCLES - 1);
  assign base_en = div_r == DIV_LAST;
  assign count = cnt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r <= '0;
      cnt_r <= '0;
      tick <= 1'b0;
    end else if (!run) begin
      div_r <= '0;
      cnt_r <= '0;
      tick <= 1'b0;
    end else begin
      div_r <= base_en ? '0 : div_r + 16'h0001;
      tick <= base_en;
      if (base_en) begin
        cnt_r <= (cnt_r >= reload) ? 32'h0 : cnt_r + 32'h1;
      end
    end
  end
endmodule : ahc_tick_gen
